// [src/pss_pkg.sv]
package pss_pkg;

    // --------------------------------------------------------------
    // Register map (byte addresses on the bus)
    // --------------------------------------------------------------
    localparam logic [7:0] PSS_OFF_PCL = 8'h00;
    localparam logic [7:0] PSS_OFF_CMD = 8'h04;
    localparam logic [7:0] PSS_OFF_TBL = 8'h08;
    localparam logic [7:0] PSS_OFF_STS = 8'h0c;
    localparam logic [7:0] PSS_OFF_PC = 8'h10;
    localparam logic [7:0] PSS_OFF_ALU = 8'h14;

    // --------------------------------------------------------------
    // Command register fields
    // --------------------------------------------------------------
    localparam int PSS_CMD_OP_LSB = 0;
    localparam int PSS_CMD_ARG_LSB = 4;
    localparam int PSS_CMD_DST_LSB = 20;
    localparam int PSS_CMD_DST_W = 9;

    // --------------------------------------------------------------
    // Sizes and reset values
    // --------------------------------------------------------------
    localparam int PSS_PC_W = 14;
    localparam int PSS_STACK_DEPTH = 12;
    localparam int PSS_SP_W = 4;
    localparam int PSS_PHASES = 4;
    localparam int PSS_TABLE_HIGH_LATCH_USED = 8;
    localparam logic [13:0] PSS_RESET_VECTOR = 14'h0000;
    localparam logic [3:0] PSS_SP_RESET = 4'h0;

    typedef enum logic [3:0] {
        PSS_OP_NOP,
        PSS_OP_BRANCH,
        PSS_OP_CALL,
        PSS_OP_SUBRET,
        PSS_OP_INTRET,
        PSS_OP_SKIP,
        PSS_OP_TABRD,
        PSS_OP_TABLE_FETCH_LAST_PAGE,
        PSS_OP_EXTENDED_TABLE_FETCH,
        PSS_OP_EXTENDED_TABLE_FETCH_LAST_PAGE,
        PSS_OP_ADD,
        PSS_OP_SUB
    } pss_op_t;

    typedef enum {
        PSS_EXEC,
        PSS_SECOND
    } pss_state_t;

    // Instruction fetch towards program memory
    typedef struct packed {
        logic [13:0] addr;
        logic rd;
    } pss_fetch_t;

    // Table-read or ALU result towards the data memory
    typedef struct packed {
        logic [8:0] dst;
        logic [7:0] data;
        logic wr;
    } pss_dwr_t;

endpackage

// [src/pss_sequencer.sv]
// What this block does
// - Four phase enables repeat; one full round is one instruction cycle.
// - PC increments at start of phase one, fetch then; decode later.
// - PC-changing instructions take two machine cycles.
// - PC advances by one per instruction unless control transfers.
// - PC is bank bit, five high bits, low byte; only low byte writable.
// - Branch, call, interrupt or reset load the target into the PC.
// - A met skip discards the prefetch and runs a dummy cycle.
// - Writing the low byte jumps within the current 256-word page.
// - A low-byte write jump inserts one dummy cycle.
// - Twelve-level return stack, not visible to software.
// - Call or interrupt acknowledge pushes the PC.
// - Subroutine or interrupt return pops the stack into the PC.
// - Reset empties the stack.
// - Full stack holds a pending interrupt until a return frees a level.
// - Call on full stack still runs, losing the oldest entry.
// - Arithmetic updates carry and zero status and writes the result.
// - Program memory is 16K words of 16 bits.
// - Execution starts at address zero after reset.
// - Table read: low byte to data register, high byte to table latch.
// - Unused table-high bits read zero.
// - Normal table reads target sector zero, extended forms either sector.
// - Every table read takes two instruction cycles.
`timescale 1ns/100ps
module pss_sequencer
    import pss_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Program memory, data valid in the phase after the fetch
    output pss_pkg::pss_fetch_t fetch,
    input wire logic [15:0] prog_word,
    // Interrupt controller
    input wire logic irq_req,
    input wire logic [13:0] irq_vector,
    output logic irq_ack,
    // Data memory write port for table reads and ALU results
    output pss_pkg::pss_dwr_t dwr,
    // Phase enables
    output logic [3:0] phase_clocks
);

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [1:0] phase;
        pss_state_t st;
        logic [13:0] pc;
        logic [3:0] sp;
        logic [13:0] tgt;
        logic dummy;
        logic [3:0] op;
        logic [15:0] arg;
        logic [8:0] dst;
        logic busy;
        logic [7:0] table_high_latch;
        logic [13:0] tptr;
        logic irq_pend;
        logic ack;
        logic carry;
        logic zero;
        logic [7:0] acc;
        logic pcl_wr;
        logic [7:0] pcl_val;
        logic aph_wr;
        logic aph_rd;
        logic [7:0] aph_addr;
        logic [13:0] fetch_addr;
        logic fetch_rd;
        pss_dwr_t dwr;
    } pss_state_s_t;

    pss_state_s_t r_ff, nxt_r;
    logic [13:0] stack_ff [PSS_STACK_DEPTH];
    logic push, pop;
    logic [13:0] push_val;
    logic stack_full;
    logic phase_start;

    assign stack_full = (r_ff.sp == 4'(PSS_STACK_DEPTH));
    assign phase_start = (r_ff.phase == 2'h0);

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        logic ap;
        logic [3:0] cmd_op;
        logic [8:0] res;
        ap = hsel && hready && htrans[1];
        res = 9'h0;
        nxt_r = r_ff;
        push = 1'b0;
        pop = 1'b0;
        push_val = r_ff.pc;
        cmd_op = 4'h0;
        nxt_r.phase = r_ff.phase + 2'h1;
        nxt_r.fetch_rd = 1'b0;
        nxt_r.dwr.wr = 1'b0;
        nxt_r.ack = 1'b0;

        // Bus address phase capture
        nxt_r.aph_wr = ap && hwrite;
        nxt_r.aph_rd = ap && !hwrite;
        nxt_r.aph_addr = haddr[7:0];

        // Interrupt requests latch even while the stack is full
        if (irq_req) begin
            nxt_r.irq_pend = 1'b1;
        end

        // Bus data-phase writes
        if (r_ff.aph_wr) begin
            case (r_ff.aph_addr)
                PSS_OFF_PCL: begin
                    nxt_r.pcl_wr = 1'b1;
                    nxt_r.pcl_val = hwdata[7:0];
                end
                PSS_OFF_CMD: begin
                    if (!r_ff.busy) begin
                        nxt_r.busy = 1'b1;
                        nxt_r.op = hwdata[PSS_CMD_OP_LSB +: 4];
                        nxt_r.arg = hwdata[PSS_CMD_ARG_LSB +: 16];
                        nxt_r.dst = hwdata[PSS_CMD_DST_LSB +: PSS_CMD_DST_W];
                    end
                end
                PSS_OFF_TBL: nxt_r.tptr = hwdata[13:0];
                PSS_OFF_ALU: nxt_r.acc = hwdata[7:0];
                default: ;
            endcase
        end

        // Phase one: advance and fetch
        if (phase_start) begin
            cmd_op = r_ff.op;
            case (r_ff.st)
                PSS_SECOND: begin
                    // Second machine cycle of a control transfer or table read
                    nxt_r.st = PSS_EXEC;
                    if (r_ff.dummy) begin
                        nxt_r.pc = r_ff.tgt + 14'h1;
                        nxt_r.fetch_addr = r_ff.tgt;
                        nxt_r.fetch_rd = 1'b1;
                        nxt_r.dummy = 1'b0;
                    end else begin
                        // Table word arrives now: bytes split out
                        nxt_r.dwr.wr = 1'b1;
                        nxt_r.dwr.data = prog_word[7:0];
                        nxt_r.dwr.dst = r_ff.dst;
                        nxt_r.table_high_latch = prog_word[15:8] & 8'((1 << PSS_TABLE_HIGH_LATCH_USED) - 1);
                        nxt_r.pc = r_ff.pc + 14'h1;
                        nxt_r.fetch_addr = r_ff.pc;
                        nxt_r.fetch_rd = 1'b1;
                    end
                    nxt_r.busy = 1'b0;
                end
                default: begin
                    nxt_r.pc = r_ff.pc + 14'h1;
                    nxt_r.fetch_addr = r_ff.pc;
                    nxt_r.fetch_rd = 1'b1;
                    if (r_ff.irq_pend && !stack_full) begin
                        push = 1'b1;
                        nxt_r.ack = 1'b1;
                        nxt_r.irq_pend = irq_req;
                        nxt_r.tgt = irq_vector;
                        nxt_r.dummy = 1'b1;
                        nxt_r.st = PSS_SECOND;
                        nxt_r.fetch_rd = 1'b0;
                        nxt_r.pc = r_ff.pc;
                    end else if (r_ff.pcl_wr) begin
                        nxt_r.tgt = {r_ff.pc[13:8], r_ff.pcl_val};
                        nxt_r.dummy = 1'b1;
                        nxt_r.st = PSS_SECOND;
                        // A new low-byte write in this same cycle wins over the clear
                        nxt_r.pcl_wr = r_ff.aph_wr && (r_ff.aph_addr == PSS_OFF_PCL);
                    end else if (r_ff.busy) begin
                        case (pss_op_t'(cmd_op))
                            PSS_OP_BRANCH: begin
                                nxt_r.tgt = r_ff.arg[13:0];
                                nxt_r.dummy = 1'b1;
                                nxt_r.st = PSS_SECOND;
                            end
                            PSS_OP_CALL: begin
                                push = 1'b1;
                                nxt_r.tgt = r_ff.arg[13:0];
                                nxt_r.dummy = 1'b1;
                                nxt_r.st = PSS_SECOND;
                            end
                            PSS_OP_SUBRET, PSS_OP_INTRET: begin
                                pop = (r_ff.sp != 4'h0);
                                nxt_r.tgt = stack_ff[r_ff.sp - 4'h1];
                                nxt_r.dummy = 1'b1;
                                nxt_r.st = PSS_SECOND;
                            end
                            PSS_OP_SKIP: begin
                                if (r_ff.arg[0]) begin
                                    nxt_r.tgt = r_ff.pc + 14'h1;
                                    nxt_r.dummy = 1'b1;
                                    nxt_r.st = PSS_SECOND;
                                end else begin
                                    nxt_r.busy = 1'b0;
                                end
                            end
                            PSS_OP_TABRD, PSS_OP_TABLE_FETCH_LAST_PAGE, PSS_OP_EXTENDED_TABLE_FETCH, PSS_OP_EXTENDED_TABLE_FETCH_LAST_PAGE: begin
                                // Opcode selects the form; normal forms force dst to sector zero
                                nxt_r.fetch_addr = (cmd_op == 4'(PSS_OP_TABLE_FETCH_LAST_PAGE) ||
                                    cmd_op == 4'(PSS_OP_EXTENDED_TABLE_FETCH_LAST_PAGE)) ? {6'h3f, r_ff.tptr[7:0]} : r_ff.tptr;
                                if ((cmd_op == 4'(PSS_OP_TABRD) || cmd_op == 4'(PSS_OP_TABLE_FETCH_LAST_PAGE))) begin
                                    nxt_r.dst = {1'b0, r_ff.dst[7:0]};
                                end
                                nxt_r.pc = r_ff.pc;
                                nxt_r.st = PSS_SECOND;
                            end
                            PSS_OP_ADD, PSS_OP_SUB: begin
                                res = (cmd_op == 4'(PSS_OP_ADD)) ? ({1'b0, r_ff.acc} + {1'b0, r_ff.arg[7:0]})
                                    : ({1'b0, r_ff.acc} - {1'b0, r_ff.arg[7:0]});
                                nxt_r.acc = res[7:0];
                                nxt_r.carry = (cmd_op == 4'(PSS_OP_ADD)) ? res[8] : !res[8];
                                nxt_r.zero = (res[7:0] == 8'h00);
                                nxt_r.dwr.wr = 1'b1;
                                nxt_r.dwr.data = res[7:0];
                                nxt_r.dwr.dst = r_ff.dst;
                                nxt_r.busy = 1'b0;
                            end
                            default: nxt_r.busy = 1'b0;
                        endcase
                    end
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Registers and stack
    // --------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            r_ff <= '0;
            r_ff.st <= PSS_EXEC;
            r_ff.pc <= PSS_RESET_VECTOR;
            r_ff.sp <= PSS_SP_RESET;
        end else begin
            r_ff <= nxt_r;
            if (push && !stack_full) begin
                r_ff.sp <= r_ff.sp + 4'h1;
            end else if (pop) begin
                r_ff.sp <= r_ff.sp - 4'h1;
            end
        end
    end

    // Full-stack push shifts out the oldest entry
    always_ff @(posedge mclk) begin
        if (push) begin
            if (stack_full) begin
                for (int i = 0; i < PSS_STACK_DEPTH - 1; i++) begin
                    stack_ff[i] <= stack_ff[i + 1];
                end
                stack_ff[PSS_STACK_DEPTH - 1] <= push_val;
            end else begin
                stack_ff[r_ff.sp] <= push_val;
            end
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    always_comb begin
        phase_clocks = 4'h1 << r_ff.phase;
    end

    assign fetch.addr = r_ff.fetch_addr;
    assign fetch.rd = r_ff.fetch_rd;
    assign dwr = r_ff.dwr;
    assign irq_ack = r_ff.ack;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Reads return zero for unmapped offsets; stack never visible
    always_comb begin
        hrdata = 32'h0;
        if (r_ff.aph_rd) begin
            case (r_ff.aph_addr)
                PSS_OFF_PCL: hrdata = {24'h0, r_ff.pc[7:0]};
                PSS_OFF_CMD: hrdata = {31'h0, r_ff.busy};
                PSS_OFF_TBL: hrdata = {10'h0, r_ff.table_high_latch, r_ff.tptr};
                PSS_OFF_STS: hrdata = {28'h0, r_ff.irq_pend, stack_full, r_ff.zero, r_ff.carry};
                PSS_OFF_PC: hrdata = {18'h0, r_ff.pc};
                PSS_OFF_ALU: hrdata = {24'h0, r_ff.acc};
                default: hrdata = 32'h0;
            endcase
        end
    end

endmodule // pss_sequencer

// [dv/pss_checker.sv]
`timescale 1ns/100ps
module pss_checker
    import pss_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Watched outputs and inputs
    input wire logic hreadyout,
    input wire logic hresp,
    input wire pss_pkg::pss_fetch_t fetch,
    input wire logic [13:0] irq_vector,
    input wire logic irq_ack,
    input wire pss_pkg::pss_dwr_t dwr,
    input wire logic [3:0] phase_clocks
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic seen_ff;
    logic nxt_seen;
    // Remembers whether the first fetch after reset has gone by
    always_comb nxt_seen = seen_ff | fetch.rd;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) seen_ff <= 1'b0;
        else seen_ff <= nxt_seen;
    end
    sequence s_rot;
        phase_clocks == 4'b0010 ##1 phase_clocks == 4'b0100 ##1 phase_clocks == 4'b1000 ##1 phase_clocks == 4'b0001;
    endsequence
    property p_phase; phase_clocks == 4'b0001 |=> s_rot; endproperty
    property p_fetch_gap; fetch.rd |=> !fetch.rd [*3]; endproperty
    property p_ready; hreadyout; endproperty
    property p_okay; !hresp; endproperty
    property p_reset_vec; fetch.rd && !seen_ff |-> fetch.addr == 14'h0000; endproperty
    property p_ack_pulse; irq_ack |=> !irq_ack [*3]; endproperty
    property p_irq_target; irq_ack |-> ##[1:12] (fetch.rd && fetch.addr == irq_vector); endproperty
    property p_wr_pulse; dwr.wr |=> !dwr.wr; endproperty
    a_phase: assert property (p_phase) else $error("phase rotation broken");
    a_fetch_gap: assert property (p_fetch_gap) else $error("fetch closer than a cycle");
    a_ready: assert property (p_ready) else $error("wait state inserted");
    a_okay: assert property (p_okay) else $error("error response");
    a_reset_vec: assert property (p_reset_vec) else $error("first fetch not at zero");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack repeated");
    a_irq_target: assert property (p_irq_target) else $error("vector not fetched");
    a_wr_pulse: assert property (p_wr_pulse) else $error("table write too long");
endmodule // pss_checker

// [dv/pss_prog_model.sv]
`timescale 1ns/100ps
module pss_prog_model
    import pss_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Program memory
    input wire pss_pkg::pss_fetch_t fetch,
    output logic [15:0] prog_word,
    // Interrupt source
    input wire logic irq_go,
    input wire logic irq_ack,
    output logic irq_req
);
    logic [13:0] addr_ff;
    logic [2:0] hold_ff;
    logic [15:0] w;
    // Pattern differs per address within a 256-word page so a wrong fetch shows
    assign w = {addr_ff[5:0], ~addr_ff[7:0], 2'b01};
    // Past the hold time the bus shows the inverse, never a stale copy
    assign prog_word = (hold_ff != 3'h0) ? w : ~w;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            addr_ff <= 14'h0000;
            hold_ff <= 3'h0;
            irq_req <= 1'b0;
        end else begin
            if (fetch.rd) begin
                addr_ff <= fetch.addr;
                hold_ff <= 3'h6;
            end else if (hold_ff != 3'h0) begin
                hold_ff <= hold_ff - 3'h1;
            end
            // Each request is a one-cycle event; a level held into the
            // acknowledge cycle would be latched again and served twice
            irq_req <= irq_go & ~irq_ack;
        end
    end
endmodule // pss_prog_model

// [dv/test_program_sequencer_stack.sv]
`timescale 1ns/100ps
module test_program_sequencer_stack;
    import pss_pkg::*;
    logic mclk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, irq_go = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = 2'b00;
    logic [13:0] irq_vector = 14'h0123, t, p, a;
    logic [15:0] w;
    logic [8:0] dst;
    logic [7:0] x, b;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, irq_ack, irq_req;
    wire logic [15:0] prog_word;
    wire logic [3:0] phase_clocks;
    pss_fetch_t fetch;
    pss_dwr_t dwr, dw_last;
    logic [13:0] fq[$];
    int n_errors = 0, cmp_count = 0, seed = 80, acks = 0, i, k;
    pss_sequencer u_dut (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .fetch(fetch), .prog_word(prog_word), .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
        .dwr(dwr), .phase_clocks(phase_clocks));
    pss_prog_model u_mem (.mclk(mclk), .nrst(nrst), .fetch(fetch), .prog_word(prog_word), .irq_go(irq_go),
        .irq_ack(irq_ack), .irq_req(irq_req));
    initial begin
        forever #5 mclk = ~mclk;
    end
    // ----------------------------
    // Monitors and helpers
    // ----------------------------
    always @(posedge mclk) begin
        if (fetch.rd === 1'b1) fq.push_back(fetch.addr);
        if (dwr.wr === 1'b1) dw_last = dwr;
        if (irq_ack === 1'b1) acks++;
    end
    function automatic logic hit(input logic [13:0] lo, input logic [13:0] hi);
        // Distance from lo keeps ranges that wrap past the top address working
        foreach (fq[j]) if (14'(fq[j] - lo) <= 14'(hi - lo)) return 1'b1;
        return 1'b0;
    endfunction
    function automatic logic [1:0] add_flags(input logic [7:0] l, input logic [7:0] r);
        logic [8:0] s;
        s = {1'b0, l} + {1'b0, r};
        return {s[7:0] == 8'h00, s[8]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, ad};
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Command writes are dropped while busy, so every command waits for it to clear
    task automatic cmd(input logic [3:0] op, input logic [15:0] arg, input logic [8:0] d);
        bus(1'b1, PSS_OFF_CMD, {3'b000, d, arg, op});
        repeat (8) @(posedge mclk);
        for (i = 0; i < 40; i++) begin
            bus(1'b0, PSS_OFF_CMD, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        check(rd[0], 1'b0, "command finished");
        repeat (8) @(posedge mclk);
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        summarize();
    end
    // ----------------------------
    // Main sequence
    // ----------------------------
    initial begin
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        bus(1'b0, PSS_OFF_STS, 32'h0);
        check(rd[3:0], 4'h0, "status after reset");
        bus(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0, "unmapped read");
        check(fq[0], 14'h0000, "first fetch");
        for (k = 0; k < 3; k++) begin
            t = 14'($random(seed)) & 14'h3f7f;
            fq.delete();
            cmd(PSS_OP_BRANCH, {2'b00, t}, 9'h000);
            check(hit(t, t), 1'b1, "branch target");
            check(hit(t + 14'h1, t + 14'h1), 1'b1, "next address");
        end
        bus(1'b0, PSS_OFF_PC, 32'h0);
        p = rd[13:0];
        x = 8'($random(seed));
        fq.delete();
        bus(1'b1, PSS_OFF_PCL, {24'h0, x});
        repeat (12) @(posedge mclk);
        check(hit({p[13:8], x}, {p[13:8], x}), 1'b1, "in-page jump");
        bus(1'b0, PSS_OFF_PC, 32'h0);
        p = rd[13:0];
        bus(1'b0, PSS_OFF_PCL, 32'h0);
        check({rd[31:8], (8'(rd[7:0] - p[7:0]) <= 8'h1)}, {24'h0, 1'b1}, "low byte read");
        $display("branch tests done");
        bus(1'b0, PSS_OFF_PC, 32'h0);
        p = rd[13:0];
        fq.delete();
        cmd(PSS_OP_CALL, 16'h0800, 9'h000);
        check(hit(14'h0800, 14'h0800), 1'b1, "call target");
        fq.delete();
        cmd(PSS_OP_SUBRET, 16'h0, 9'h000);
        check(hit(p, p + 14'h4), 1'b1, "return address");
        for (k = 0; k < 12; k++) begin
            cmd(PSS_OP_CALL, 16'(k * 16 + 16'h0200), 9'h000);
            bus(1'b0, PSS_OFF_STS, 32'h0);
            check(rd[2], k == 11, "stack full flag");
        end
        irq_go <= 1'b1;
        @(posedge mclk);
        irq_go <= 1'b0;
        repeat (24) @(posedge mclk);
        bus(1'b0, PSS_OFF_STS, 32'h0);
        check({rd[3], 14'(acks)}, {1'b1, 14'h0}, "irq held while full");
        fq.delete();
        cmd(PSS_OP_SUBRET, 16'h0, 9'h000);
        repeat (16) @(posedge mclk);
        check(acks, 1, "irq after return");
        check(hit(irq_vector, irq_vector), 1'b1, "vector fetch");
        fq.delete();
        cmd(PSS_OP_CALL, 16'h0abc, 9'h000);
        check(hit(14'h0abc, 14'h0abc), 1'b1, "call on full stack");
        fq.delete();
        cmd(PSS_OP_INTRET, 16'h0, 9'h000);
        check(hit(irq_vector, irq_vector + 14'h10), 1'b1, "interrupt return");
        $display("stack tests done");
        for (k = 6; k < 10; k++) begin
            t = 14'($random(seed));
            dst = 9'($random(seed));
            bus(1'b1, PSS_OFF_TBL, {18'h0, t});
            cmd(4'(k), 16'h0, dst);
            a = (k == 7 || k == 9) ? {6'h3f, t[7:0]} : t;
            w = {a[5:0], ~a[7:0], 2'b01};
            check({dw_last.dst, dw_last.data}, {(k < 8) ? {1'b0, dst[7:0]} : dst, w[7:0]}, "table low");
            bus(1'b0, PSS_OFF_TBL, 32'h0);
            check(rd[21:14], w[15:8], "table high");
        end
        $display("table tests done");
        for (k = 0; k < 6; k++) begin
            x = (k == 0) ? 8'hff : 8'($random(seed));
            b = (k == 0) ? 8'h01 : 8'($random(seed));
            bus(1'b1, PSS_OFF_ALU, {24'h0, x});
            cmd(PSS_OP_ADD, {8'h0, b}, 9'h000);
            bus(1'b0, PSS_OFF_STS, 32'h0);
            check(rd[1:0], add_flags(x, b), "add flags");
        end
        bus(1'b1, PSS_OFF_ALU, {24'h0, x});
        cmd(PSS_OP_SUB, {8'h0, x}, 9'h000);
        bus(1'b0, PSS_OFF_STS, 32'h0);
        check(rd[1], 1'b1, "sub zero");
        cmd(PSS_OP_SKIP, 16'h1, 9'h000);
        cmd(PSS_OP_NOP, 16'h0, 9'h000);
        $display("alu tests done");
        cmd(PSS_OP_CALL, 16'h0400, 9'h000);
        bus(1'b0, PSS_OFF_STS, 32'h0);
        check(rd[2], 1'b1, "stack full before reset");
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        fq.delete();
        nrst <= 1'b1;
        @(posedge mclk);
        bus(1'b0, PSS_OFF_STS, 32'h0);
        check(rd[2], 1'b0, "stack empty after reset");
        check(fq[0], 14'h0000, "restart at zero");
        $display("reset test done");
        summarize();
    end
endmodule // test_program_sequencer_stack
bind pss_sequencer pss_checker u_chk (.mclk(mclk), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp),
    .fetch(fetch), .irq_vector(irq_vector), .irq_ack(irq_ack), .dwr(dwr), .phase_clocks(phase_clocks));
